// >>> design/ibl_pkg.sv
/*
 * constants and carrier types of the link status and statistics command
 * handler. assumes an upstream packet parser that has already checked the
 * common header, and a downstream framer that adds header and checksum.
 */
package ibl_pkg;

    localparam logic [7:0] CMD_LINK = 8'h38;
    localparam logic [7:0] CMD_STATS = 8'h39;
    localparam logic [7:0] RSP_LINK = 8'hB8;
    localparam logic [7:0] RSP_STATS = 8'hB9;
    localparam logic [15:0] REASON_NONE = 16'h0000;

    // payload length in bytes, counted from packet byte 16 up to the checksum
    localparam logic [6:0] LEN_LINK = 7'h1C;
    localparam logic [6:0] LEN_STATS = 7'h40;

    // payload word indices (word 0 sits at packet byte 16)
    localparam logic [4:0] WI_CODES = 5'h00;
    localparam logic [4:0] WI_LINK_A = 5'h03;
    localparam logic [4:0] WI_LINK_B = 5'h04;
    localparam logic [4:0] WI_CNT_FIRST = 5'h01;

    localparam logic [3:0] PHYS_LINK_UP = 4'h5;
    localparam logic [7:0] WIDTH_VALID = 8'h0F;
    localparam logic [31:0] CNT_UNSUPPORTED = 32'hFFFFFFFF;
    localparam int NUM_CNT_MAX = 15;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LINK = 8'h04;
    localparam logic [7:0] REG_WIDTH = 8'h08;
    localparam logic [7:0] REG_SPEED = 8'h0C;
    localparam logic [7:0] REG_CNT_MASK = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // field positions
    localparam int LINK_TYPE_BIT = 0;
    localparam int PHYS_LSB = 4;
    localparam int LOG_LSB = 8;
    localparam int ACTIVE_LSB = 0;
    localparam int SUPPORTED_LSB = 8;
    localparam int BUSY_BIT = 24;

    // values after reset
    localparam logic CTRL_IB_ENABLE_RST = 1'b1;
    localparam logic [14:0] CNT_MASK_RST = 15'h7FFF;

    typedef struct packed {
        logic [7:0] code;
        logic checksumOk;
        logic idOk;
    } ibl_cmd_t;

    typedef struct packed {
        logic linkType;
        logic [3:0] physState;
        logic [3:0] logState;
        logic [7:0] activeLaneWidthMap;
        logic [7:0] supportedLaneWidthMap;
        logic [7:0] activeRateMap;
        logic [7:0] supportedRateMap;
    } ibl_link_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } ibl_phase_t;

    typedef struct packed {
        ibl_phase_t phase;
        logic isStats;
        logic [6:0] pos;
        logic [6:0] len;
        logic [23:0] shift;
        ibl_link_cfg_t snap;
        logic [14:0] maskSnap;
        logic ibEnable;
        ibl_link_cfg_t cfg;
        logic [14:0] cntMask;
        logic [7:0] linkCount;
        logic [7:0] statsCount;
        logic [7:0] dropCount;
        logic cmdReady;
        logic respValid;
        logic respLast;
        logic cmdRejected;
        logic [7:0] respByte;
        logic [31:0] regRdata;
    } ibl_state_t;

endpackage : ibl_pkg

// >>> design/ibl_link_words.sv
/*
 * builds the two link status payload words from a link configuration.
 * purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps

module ibl_link_words
    import ibl_pkg::*;
(
    input wire ibl_pkg::ibl_link_cfg_t cfg,
    output logic [31:0] wordA,
    output logic [31:0] wordB
);
    logic isIb;
    logic isUp;

    always_comb
    begin
        isIb = cfg.linkType;
        isUp = cfg.linkType && (cfg.physState == PHYS_LINK_UP);
        wordA = 32'h00000000;
        wordB = 32'h00000000;
        if (isUp)
        begin
            wordA[31:24] = cfg.activeLaneWidthMap & WIDTH_VALID;
            wordB[23:16] = cfg.activeRateMap;
        end
        if (isIb)
        begin
            wordA[23:16] = cfg.supportedLaneWidthMap & WIDTH_VALID;
            wordA[7:4] = cfg.physState;
            wordA[3:0] = cfg.logState;
            wordB[7:0] = cfg.supportedRateMap;
        end
        wordA[8] = cfg.linkType;
    end

endmodule : ibl_link_words

// >>> design/ibl_cmd_handler.sv
/*
 * link status and statistics command handler of one sideband channel.
 * assumes commands arrive already parsed with checksum and id verdicts,
 * and that a framer consumes the payload byte stream and wraps it.
 */
`timescale 1ns/1ps

// Contract
// - code 0x38 from the controller is recognised as the link status query.
// - link status handled only when InfiniBand support is enabled.
// - good link status command always answered with response code 0xB8.
// - response codes bytes 16-19, state bytes 28-31, speeds next word.
// - active width bitmap, zero unless InfiniBand and physical link up.
// - supported width bitmap when InfiniBand, zero for Ethernet.
// - link type bit 0: zero Ethernet, one InfiniBand.
// - physical state zero for Ethernet, link up is 0x5, phy test 0x7.
// - logical state zero for Ethernet, then down, init, arm, active.
// - active speed bitmap SDR to NDR, zero unless InfiniBand and up.
// - supported speed bitmap when InfiniBand, 0x00 for Ethernet.
// - code 0x39 is recognised as the statistics request.
// - statistics handled only when InfiniBand support is enabled.
// - good statistics command always answered with response code 0xB9.
// - unsupported counters are reported as 0xFFFFFFFF.
module ibl_cmd_handler #(
    parameter bit IB_CAPABLE = 1'b1,
    parameter int NUM_CNT = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire ibl_pkg::ibl_cmd_t cmd,
    output logic cmdReady,
    output logic cmdRejected,
    output logic respValid,
    output logic [7:0] respByte,
    output logic respLast,
    input wire logic respReady,
    input wire logic [ibl_pkg::NUM_CNT_MAX-1:0][31:0] statCounters,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata
);
    import ibl_pkg::*;

    if (NUM_CNT < 1 || NUM_CNT > NUM_CNT_MAX)
    begin : g_bad_num_cnt
        $error("NUM_CNT must lie between 1 and 15");
    end

    ibl_state_t q;
    ibl_state_t next_q;
    logic [31:0] linkWordA;
    logic [31:0] linkWordB;
    logic [31:0] wordAt;
    logic [6:0] loadPos;
    logic [3:0] cntIdx;
    logic loadByte;
    logic cmdGood;

    // words come from the snapshot so one answer never mixes two configs
    ibl_link_words u_words (
        .cfg(q.snap),
        .wordA(linkWordA),
        .wordB(linkWordB)
    );

    always_comb
    begin
        loadPos = q.respValid ? 7'(q.pos + 7'h01) : 7'h00;
        cntIdx = 4'(loadPos[6:2] - WI_CNT_FIRST);
        wordAt = 32'h00000000;
        if (loadPos[6:2] == WI_CODES)
        begin
            wordAt = {8'h00, q.isStats ? RSP_STATS : RSP_LINK, REASON_NONE};
        end
        else if (q.isStats)
        begin
            if (32'(cntIdx) < NUM_CNT && q.maskSnap[cntIdx])
            begin
                wordAt = statCounters[cntIdx];
            end
            else
            begin
                wordAt = CNT_UNSUPPORTED;
            end
        end
        else if (loadPos[6:2] == WI_LINK_A)
        begin
            wordAt = linkWordA;
        end
        else if (loadPos[6:2] == WI_LINK_B)
        begin
            wordAt = linkWordB;
        end
    end

    always_comb
    begin
        next_q = q;
        next_q.cmdRejected = 1'b0;
        next_q.regRdata = 32'h00000000;
        cmdGood = cmd.checksumOk && cmd.idOk;
        loadByte = (q.phase == ST_SEND) && (!q.respValid || respReady)
            && !(q.respValid && q.respLast);
        case (q.phase)
            ST_IDLE:
            begin
                if (cmdValid && q.cmdReady)
                begin
                    if (!cmdGood)
                    begin
                        next_q.dropCount = 8'(q.dropCount + 8'h01);
                    end
                    else if (q.ibEnable && (cmd.code == CMD_LINK
                        || cmd.code == CMD_STATS))
                    begin
                        next_q.phase = ST_SEND;
                        next_q.isStats = (cmd.code == CMD_STATS);
                        next_q.len = (cmd.code == CMD_STATS) ? LEN_STATS
                            : LEN_LINK;
                        next_q.snap = q.cfg;
                        next_q.maskSnap = q.cntMask;
                        next_q.cmdReady = 1'b0;
                        next_q.respValid = 1'b0;
                        next_q.respLast = 1'b0;
                        if (cmd.code == CMD_STATS)
                        begin
                            next_q.statsCount = 8'(q.statsCount + 8'h01);
                        end
                        else
                        begin
                            next_q.linkCount = 8'(q.linkCount + 8'h01);
                        end
                    end
                    else
                    begin
                        // left to the generic handler to answer
                        next_q.cmdRejected = 1'b1;
                    end
                end
            end
            ST_SEND:
            begin
                if (loadByte)
                begin
                    next_q.respValid = 1'b1;
                    next_q.pos = loadPos;
                    next_q.respLast = (loadPos == 7'(q.len - 7'h01));
                    if (loadPos[1:0] == 2'b00)
                    begin
                        next_q.respByte = wordAt[31:24];
                        next_q.shift = wordAt[23:0];
                    end
                    else
                    begin
                        next_q.respByte = q.shift[23:16];
                        next_q.shift = {q.shift[15:0], 8'h00};
                    end
                end
                else if (q.respValid && q.respLast && respReady)
                begin
                    next_q.phase = ST_IDLE;
                    next_q.respValid = 1'b0;
                    next_q.respLast = 1'b0;
                    next_q.cmdReady = 1'b1;
                end
            end
            default:
            begin
                next_q.phase = ST_IDLE;
                next_q.cmdReady = 1'b1;
            end
        endcase
        if (regWrite)
        begin
            if (regAddr == REG_CTRL)
            begin
                next_q.ibEnable = regWdata[0] && IB_CAPABLE;
            end
            else if (regAddr == REG_LINK)
            begin
                next_q.cfg.linkType = regWdata[LINK_TYPE_BIT];
                next_q.cfg.physState = regWdata[PHYS_LSB +: 4];
                next_q.cfg.logState = regWdata[LOG_LSB +: 4];
            end
            else if (regAddr == REG_WIDTH)
            begin
                next_q.cfg.activeLaneWidthMap = regWdata[ACTIVE_LSB +: 8];
                next_q.cfg.supportedLaneWidthMap =
                    regWdata[SUPPORTED_LSB +: 8];
            end
            else if (regAddr == REG_SPEED)
            begin
                next_q.cfg.activeRateMap = regWdata[ACTIVE_LSB +: 8];
                next_q.cfg.supportedRateMap = regWdata[SUPPORTED_LSB +: 8];
            end
            else if (regAddr == REG_CNT_MASK)
            begin
                next_q.cntMask = regWdata[14:0];
            end
        end
        if (regRead)
        begin
            if (regAddr == REG_CTRL)
            begin
                next_q.regRdata[0] = q.ibEnable;
            end
            else if (regAddr == REG_LINK)
            begin
                next_q.regRdata[LINK_TYPE_BIT] = q.cfg.linkType;
                next_q.regRdata[PHYS_LSB +: 4] = q.cfg.physState;
                next_q.regRdata[LOG_LSB +: 4] = q.cfg.logState;
            end
            else if (regAddr == REG_WIDTH)
            begin
                next_q.regRdata[ACTIVE_LSB +: 8] = q.cfg.activeLaneWidthMap;
                next_q.regRdata[SUPPORTED_LSB +: 8] =
                    q.cfg.supportedLaneWidthMap;
            end
            else if (regAddr == REG_SPEED)
            begin
                next_q.regRdata[ACTIVE_LSB +: 8] = q.cfg.activeRateMap;
                next_q.regRdata[SUPPORTED_LSB +: 8] = q.cfg.supportedRateMap;
            end
            else if (regAddr == REG_CNT_MASK)
            begin
                next_q.regRdata[14:0] = q.cntMask;
            end
            else if (regAddr == REG_STATUS)
            begin
                next_q.regRdata[23:0] = {q.dropCount, q.statsCount,
                    q.linkCount};
                next_q.regRdata[BUSY_BIT] = (q.phase == ST_SEND);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.phase <= ST_IDLE;
            q.ibEnable <= CTRL_IB_ENABLE_RST && IB_CAPABLE;
            q.cntMask <= CNT_MASK_RST;
            q.cmdReady <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign cmdReady = q.cmdReady;
    assign cmdRejected = q.cmdRejected;
    assign respValid = q.respValid;
    assign respByte = q.respByte;
    assign respLast = q.respLast;
    assign regRdata = q.regRdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // link byte positions relative to packet byte 16
    logic linkByte;
    assign linkByte = q.respValid && !q.isStats;

    property p_link_start;
        cmdValid && q.cmdReady && cmd.checksumOk && cmd.idOk && q.ibEnable
            && cmd.code == CMD_LINK |-> ##2 (q.respValid && !q.isStats
            && q.pos == 7'h00 && q.respByte == 8'h00);
    endproperty
    a_link_start: assert property (p_link_start)
        else $error("link status query not started two cycles later");

    property p_stats_start;
        cmdValid && q.cmdReady && cmd.checksumOk && cmd.idOk && q.ibEnable
            && cmd.code == CMD_STATS |=> q.isStats ##1 q.respValid;
    endproperty
    a_stats_start: assert property (p_stats_start)
        else $error("statistics request not started");

    property p_disabled;
        cmdValid && q.cmdReady && cmd.checksumOk && cmd.idOk && !q.ibEnable
            |=> q.cmdRejected && q.phase == ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("command served while support is disabled");

    property p_drop_bad;
        cmdValid && q.cmdReady && !(cmd.checksumOk && cmd.idOk)
            |=> q.phase == ST_IDLE && !q.cmdRejected
            && q.dropCount == 8'($past(q.dropCount) + 8'h01);
    endproperty
    a_drop_bad: assert property (p_drop_bad)
        else $error("bad command not dropped");

    property p_link_code;
        linkByte && q.pos == 7'h01 |-> q.respByte == RSP_LINK;
    endproperty
    a_link_code: assert property (p_link_code)
        else $error("wrong link status response code");

    property p_stats_code;
        q.respValid && q.isStats && q.pos == 7'h01
            |-> q.respByte == RSP_STATS;
    endproperty
    a_stats_code: assert property (p_stats_code)
        else $error("wrong statistics response code");

    property p_active_width;
        linkByte && q.pos == 7'h0C && !(q.snap.linkType
            && q.snap.physState == PHYS_LINK_UP) |-> q.respByte == 8'h00;
    endproperty
    a_active_width: assert property (p_active_width)
        else $error("active width not zero while link down");

    property p_supported_width;
        linkByte && q.pos == 7'h0D && !q.snap.linkType
            |-> q.respByte == 8'h00;
    endproperty
    a_supported_width: assert property (p_supported_width)
        else $error("supported width not zero on Ethernet");

    // judged per byte, so a stall between the two bytes cannot trip it
    property p_link_type;
        linkByte && (q.pos == 7'h0E || q.pos == 7'h0F)
            |-> (q.pos == 7'h0F) ? (q.snap.linkType || q.respByte == 8'h00)
            : (q.respByte == {7'h00, q.snap.linkType});
    endproperty
    a_link_type: assert property (p_link_type)
        else $error("link type byte or Ethernet state byte wrong");

    property p_rates;
        linkByte && q.pos == 7'h11 && !(q.snap.linkType
            && q.snap.physState == PHYS_LINK_UP) |-> q.respByte == 8'h00;
    endproperty
    a_rates: assert property (p_rates)
        else $error("active speed not zero while link down");

    property p_supp_rates;
        linkByte && q.pos == 7'h13 && !q.snap.linkType
            |-> q.respByte == 8'h00;
    endproperty
    a_supp_rates: assert property (p_supp_rates)
        else $error("supported speed not zero on Ethernet");

    property p_unsupported;
        q.respValid && q.isStats && q.pos >= 7'h04
            && !q.maskSnap[4'(q.pos[6:2] - WI_CNT_FIRST)]
            |-> q.respByte == 8'hFF;
    endproperty
    a_unsupported: assert property (p_unsupported)
        else $error("unsupported counter not all ones");

    property p_reserved;
        linkByte && ((q.pos >= 7'h04 && q.pos <= 7'h0B) || q.pos == 7'h10
            || q.pos >= 7'h14) |-> q.respByte == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved link status byte not zero");

    property p_last;
        q.respLast |-> q.respValid && q.pos == 7'(q.len - 7'h01);
    endproperty
    a_last: assert property (p_last)
        else $error("last flag at the wrong byte");

endmodule : ibl_cmd_handler

// >>> test/ibl_ctrl_model.sv
/*
 * behavioural management controller: issues parsed commands and takes the
 * response byte stream, stalling at random. assumes the handler contract.
 */
`timescale 1ns/1ps

module ibl_ctrl_model
    import ibl_pkg::*;
(
    input wire logic clk,
    output ibl_pkg::ibl_cmd_t cmd,
    output logic cmdValid,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire logic [7:0] respByte,
    input wire logic respLast,
    output logic respReady
);
    logic [7:0] rx[$];
    int lastAt = -1;
    int stall = 0;

    initial
    begin
        cmdValid = 1'b0;
        cmd = '0;
        respReady = 1'b0;
    end

    // released lines show the inverse so a stale command never looks fresh
    task automatic send(input logic [7:0] code, input logic cs, input logic id);
        ibl_cmd_t c;
        int n;
        c = '{code: code, checksumOk: cs, idOk: id};
        n = 0;
        @(posedge clk);
        cmdValid <= 1'b1;
        cmd <= c;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmdReady !== 1'b1 && n < 400);
        cmdValid <= 1'b0;
        cmd <= ~c;
    endtask : send

    always @(posedge clk)
    begin
        respReady <= ($urandom_range(99) >= stall);
        if (respValid === 1'b1 && respReady === 1'b1)
        begin
            if (respLast === 1'b1)
                lastAt <= rx.size();
            rx.push_back(respByte);
        end
    end
endmodule : ibl_ctrl_model

// >>> test/ibl_cmd_handler_tb_top.sv
/*
 * self-checking bench of the command handler: random link and counter
 * settings, stalls, drops, refusals and register reads.
 * assumes the controller model beside it and a 100 MHz clock.
 */
`timescale 1ns/1ps

module ibl_cmd_handler_tb_top;
    import ibl_pkg::*;
    // fewer counters than slots, so the top ones must read all ones
    localparam int NCNT = 12;
    logic clk, reset, cmdValid, cmdReady, cmdRejected;
    logic respValid, respLast, respReady, regWrite, regRead;
    ibl_cmd_t cmd;
    logic [7:0] respByte, regAddr;
    logic [31:0] regWdata, regRdata, d;
    logic [14:0][31:0] stat;
    logic [14:0] mask;
    logic lt;
    logic [3:0] ph, lg;
    logic [7:0] aw, sw, as, ss;
    int errors = 0, comparisons = 0, rejects = 0;
    int nLink = 0, nStats = 0, nDrop = 0;

    ibl_cmd_handler #(.IB_CAPABLE(1'b1), .NUM_CNT(NCNT)) i_dut (
        .clk(clk), .reset(reset), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .cmdRejected(cmdRejected),
        .respValid(respValid), .respByte(respByte), .respLast(respLast),
        .respReady(respReady), .statCounters(stat), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata));

    ibl_ctrl_model i_ctrl (
        .clk(clk), .cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .respValid(respValid), .respByte(respByte), .respLast(respLast),
        .respReady(respReady));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
        if (cmdRejected === 1'b1)
            rejects++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic regWr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr

    task automatic regRd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        v = regRdata;
    endtask : regRd

    function automatic logic [7:0] linkByte(int p);
        logic up;
        up = lt && ph == PHYS_LINK_UP;
        case (p)
            1: return RSP_LINK;
            12: return up ? aw & 8'h0F : 8'h00;
            13: return lt ? sw & 8'h0F : 8'h00;
            14: return {7'h00, lt};
            15: return lt ? {ph, lg} : 8'h00;
            17: return up ? as : 8'h00;
            19: return lt ? ss : 8'h00;
            default: return 8'h00;
        endcase
    endfunction : linkByte

    function automatic logic [7:0] statByte(int p);
        int k;
        logic [31:0] w;
        if (p < 4)
            return (p == 1) ? RSP_STATS : 8'h00;
        k = (p - 4) / 4;
        w = (k >= NCNT || !mask[k]) ? 32'hFFFFFFFF : stat[k];
        return w[8 * (3 - p % 4) +: 8];
    endfunction : statByte

    // sends c0 then n-1 statistics requests one after another, then checks the whole stream
    task automatic run(input logic [7:0] c0, input int n);
        int len, m, q;
        len = 0;
        i_ctrl.rx.delete();
        i_ctrl.lastAt = -1;
        for (int i = 0; i < n; i++)
        begin
            i_ctrl.send(i ? CMD_STATS : c0, 1'b1, 1'b1);
            len += (i || c0 == CMD_STATS) ? 64 : 28;
        end
        for (m = 0; m < 3000 && i_ctrl.rx.size() < len; m++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        check(i_ctrl.rx.size(), len);
        check(i_ctrl.lastAt, len - 1);
        for (int p = 0; p < len; p++)
        begin
            q = (n > 1) ? p - 28 : p;
            if (c0 == CMD_LINK && q < 0 || c0 == CMD_LINK && n == 1)
                check(i_ctrl.rx[p], linkByte(p));
            else
                check(i_ctrl.rx[p], statByte(q));
        end
    endtask : run

    task automatic silent(input logic [7:0] c, input logic ok, input int rej);
        int r0;
        r0 = rejects;
        i_ctrl.rx.delete();
        i_ctrl.send(c, ok, 1'b1);
        i_ctrl.send(c, 1'b1, ok);
        repeat (8) @(posedge clk);
        check(i_ctrl.rx.size(), 0);
        check(rejects - r0, rej);
    endtask : silent

    task automatic setLink();
        regWr(REG_LINK, {20'h0, lg, ph, 3'h0, lt});
        regWr(REG_WIDTH, {16'h0, sw, aw});
        regWr(REG_SPEED, {16'h0, ss, as});
        run(CMD_LINK, 1);
        nLink++;
    endtask : setLink

    initial
    begin
        #500000;
        errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(32'hB9790C9F));
        reset = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        stat = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        check(cmdReady, 1'b1);
        regRd(REG_CTRL, d);
        check(d, 32'h1);
        regRd(REG_CNT_MASK, d);
        check(d, 32'h7FFF);
        regRd(8'h40, d);
        check(d, 32'h0);
        // ethernet with stale widths, speeds and states that must be hidden
        {lt, ph, lg} = {1'b0, 4'h5, 4'h4};
        {aw, sw, as, ss} = 32'hFFFFFFFF;
        setLink();
        for (int i = 0; i < 8; i++)
        begin
            lt = (i < 2) ? 1'b1 : 1'($urandom);
            ph = (i == 0) ? 4'h5 : (i == 1) ? 4'h7 : 4'($urandom_range(7));
            lg = 4'($urandom_range(4));
            {aw, sw, as, ss} = $urandom;
            i_ctrl.stall = i * 10;
            setLink();
        end
        regRd(REG_LINK, d);
        check(d, {20'h0, lg, ph, 3'h0, lt});
        for (int i = 0; i < 3; i++)
        begin
            mask = (i == 0) ? 15'h7FFF : 15'($urandom);
            for (int k = 0; k < 15; k++)
                stat[k] <= $urandom;
            regWr(REG_CNT_MASK, {17'h0, mask});
            run(CMD_STATS, 1);
            nStats++;
        end
        i_ctrl.stall = 0;
        run(CMD_LINK, 2);
        nLink++;
        nStats++;
        silent(CMD_LINK, 1'b0, 0);
        silent(CMD_STATS, 1'b0, 0);
        nDrop += 4;
        silent(8'h40, 1'b1, 2);
        regWr(REG_CTRL, 32'h0);
        silent(CMD_LINK, 1'b1, 2);
        silent(CMD_STATS, 1'b1, 2);
        regRd(REG_STATUS, d);
        check(d, {8'h0, nDrop[7:0], nStats[7:0], nLink[7:0]});
        conclude();
    end
endmodule : ibl_cmd_handler_tb_top
